// file: pkg/adcst_map.svh
// register map and timing constants for the converter start/trigger control
// assumes inclusion by bare name from the design file, the checker and the bench
`ifndef ADCST_MAP_SVH
`define ADCST_MAP_SVH
`define ADCST_CTRL_ADDR    32'h4001C000
`define ADCST_SEL_LSB      0
`define ADCST_SEL_MSB      7
`define ADCST_DIV_LSB      8
`define ADCST_DIV_MSB      15
`define ADCST_BURST_BIT    16
`define ADCST_BURST_CLOCKS_PER_CONVERSION_LSB     17
`define ADCST_BURST_CLOCKS_PER_CONVERSION_MSB     19
`define ADCST_PDN_BIT      21
`define ADCST_START_LSB    24
`define ADCST_START_MSB    26
`define ADCST_EDGE_BIT     27
`define ADCST_CTRL_RESET   32'h00000000
`define ADCST_WMASK        32'h0F2FFFFF
`define ADCST_FULL_BURST_CLOCKS_PER_CONVERSION    4'hB
`define ADCST_FULL_BITS    4'hA
`endif

// file: pkg/adcst_pkg.sv
// types for the converter start/trigger control block
// assumes the map header sits beside it
package adcst_pkg;
  typedef enum logic [2:0] {
    ADCST_ST_NONE = 3'h0,
    ADCST_ST_NOW  = 3'h1,
    ADCST_ST_SCP0 = 3'h2,
    ADCST_ST_LCP0 = 3'h3,
    ADCST_ST_LMT0 = 3'h4,
    ADCST_ST_LMT1 = 3'h5,
    ADCST_ST_SMT0 = 3'h6,
    ADCST_ST_SMT1 = 3'h7
  } adcst_start_e;

  typedef enum logic [1:0] {
    ADCST_IDLE = 2'h0,
    ADCST_CONV = 2'h1,
    ADCST_BRST = 2'h2
  } adcst_fsm_e;

  typedef struct packed {
    logic short_timer0_capture0;
    logic long_timer0_capture0;
    logic long_timer0_match0;
    logic long_timer0_match1;
    logic short_timer0_match0;
    logic short_timer0_match1;
  } adcst_trig_s;

  typedef struct packed {
    logic [31:0]  ctrl;
    logic [5:0]   sync1;
    logic [5:0]   sync2;
    logic         sel_prev;
    logic         sel_prev_ok;
    adcst_fsm_e   fsm;
    logic [3:0]   cnt;
    logic         conv_start;
    logic         conv_busy;
    logic         conv_done;
    logic [3:0]   conv_bits;
    logic [31:0]  rdata;
  } adcst_state_s;
endpackage

// file: rtl/adcst_ctrl.sv
// converter control register with start-trigger selection and conversion pacing
// assumes a 10 MHz ref_clk, trigger inputs asynchronous to it, one-cycle bus strobes
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "adcst_map.svh"

module adcst_ctrl
  import adcst_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire adcst_trig_s trig,
  output logic      [31:0] converter_control,
  output logic             conv_start,
  output logic             conv_busy,
  output logic             conv_done,
  output logic      [3:0]  conv_bits
);

  adcst_state_s s_q;
  adcst_state_s s_d;

  logic         ctrl_hit;
  logic [2:0]   start_f;
  logic         edge_f;
  logic         burst_f;
  logic [2:0]   burst_clocks_per_conversion_f;
  logic         sel_now;
  logic         fire;
  logic [3:0]   len;

  assign ctrl_hit = addr == `ADCST_CTRL_ADDR;
  assign start_f  = s_q.ctrl[`ADCST_START_MSB:`ADCST_START_LSB];
  assign edge_f   = s_q.ctrl[`ADCST_EDGE_BIT];
  assign burst_f  = s_q.ctrl[`ADCST_BURST_BIT];
  assign burst_clocks_per_conversion_f   = s_q.ctrl[`ADCST_BURST_CLOCKS_PER_CONVERSION_MSB:`ADCST_BURST_CLOCKS_PER_CONVERSION_LSB];
  assign len      = `ADCST_FULL_BURST_CLOCKS_PER_CONVERSION - {1'b0, burst_clocks_per_conversion_f};

  // only second-stage samples feed the selector
  always_comb begin
    unique case (adcst_start_e'(start_f))
      ADCST_ST_SCP0: sel_now = s_q.sync2[5];
      ADCST_ST_LCP0: sel_now = s_q.sync2[4];
      ADCST_ST_LMT0: sel_now = s_q.sync2[3];
      ADCST_ST_LMT1: sel_now = s_q.sync2[2];
      ADCST_ST_SMT0: sel_now = s_q.sync2[1];
      ADCST_ST_SMT1: sel_now = s_q.sync2[0];
      default:       sel_now = 1'b0;
    endcase
  end

  // edge only counts when previous sample came from the same source
  always_comb begin
    fire = 1'b0;
    if (start_f >= 3'h2 && s_q.sel_prev_ok) begin
      fire = edge_f ? (s_q.sel_prev & ~sel_now)
                    : (~s_q.sel_prev & sel_now);
    end
  end

  always_comb begin
    s_d            = s_q;
    s_d.sync1      = trig;
    s_d.sync2      = s_q.sync1;
    s_d.sel_prev   = sel_now;
    s_d.sel_prev_ok = start_f >= 3'h2;
    s_d.conv_start = 1'b0;
    s_d.conv_done  = 1'b0;
    s_d.rdata      = 32'h00000000;

    if (rd && ctrl_hit) begin
      // reserved bits simply read as zero, a legal undefined value
      s_d.rdata = s_q.ctrl & `ADCST_WMASK;
    end

    unique case (s_q.fsm)
      ADCST_IDLE: begin
        if (burst_f) begin
          s_d.fsm        = ADCST_BRST;
          s_d.cnt        = len;
          s_d.conv_start = 1'b1;
          s_d.conv_bits  = `ADCST_FULL_BITS - {1'b0, burst_clocks_per_conversion_f};
        end else if (fire) begin
          s_d.fsm        = ADCST_CONV;
          s_d.cnt        = `ADCST_FULL_BURST_CLOCKS_PER_CONVERSION;
          s_d.conv_start = 1'b1;
          s_d.conv_bits  = `ADCST_FULL_BITS;
        end
      end
      ADCST_CONV, ADCST_BRST: begin
        if (s_q.cnt <= 4'h1) begin
          s_d.conv_done = 1'b1;
          if (s_q.fsm == ADCST_BRST && burst_f) begin
            s_d.cnt        = len;
            s_d.conv_start = 1'b1;
            s_d.conv_bits  = `ADCST_FULL_BITS - {1'b0, burst_clocks_per_conversion_f};
          end else begin
            s_d.fsm = ADCST_IDLE;
          end
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      default: s_d.fsm = ADCST_IDLE;
    endcase

    if (wr && ctrl_hit) begin
      s_d.ctrl = wdata & `ADCST_WMASK;
      // start-now ignored under burst; burst owns the converter
      if (wdata[`ADCST_START_MSB:`ADCST_START_LSB] == ADCST_ST_NOW
          && !wdata[`ADCST_BURST_BIT]) begin
        s_d.fsm        = ADCST_CONV;
        s_d.cnt        = `ADCST_FULL_BURST_CLOCKS_PER_CONVERSION;
        s_d.conv_start = 1'b1;
        s_d.conv_bits  = `ADCST_FULL_BITS;
      end
      // zero start arms nothing; the selector yields no edge
      s_d.sel_prev_ok = 1'b0;
    end
    s_d.conv_busy = s_d.fsm != ADCST_IDLE;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{ctrl: `ADCST_CTRL_RESET, fsm: ADCST_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata             = s_q.rdata;
  assign converter_control = s_q.ctrl;
  assign conv_start        = s_q.conv_start;
  assign conv_busy         = s_q.conv_busy;
  assign conv_done         = s_q.conv_done;
  assign conv_bits         = s_q.conv_bits;

endmodule

// file: dv/adcst_timers.sv
// timer model: trigger lines follow bench levels
// assumes levels change after a clock edge
`timescale 1ns/1ps
module adcst_timers
  import adcst_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [5:0] lv,
  output adcst_trig_s     trig
);
  // internal compare outputs, no pin
  always_ff @(posedge ref_clk) trig <= lv;
endmodule

// file: dv/adcst_props.sv
// checker: register, start and pacing relations
// assumes bind onto adcst_ctrl
`timescale 1ns/1ps
`include "adcst_map.svh"
module adcst_props (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic [31:0] converter_control,
  input wire logic        conv_start,
  input wire logic        conv_busy,
  input wire logic        conv_done,
  input wire logic [3:0]  conv_bits
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire       hit = addr == `ADCST_CTRL_ADDR;
  wire       bst = converter_control[16];
  wire [2:0] st  = converter_control[26:24];
  sequence busy11; conv_busy[*8] ##1 conv_busy[*3]; endsequence
  wr_mask_a: assert property (wr && hit |=>
    converter_control == ($past(wdata) & `ADCST_WMASK)) else $error("write");
  rd_data_a: assert property (rd |=>
    rdata == ($past(hit) ? converter_control : 32'h0)) else $error("read");
  resv_zero_a: assert property (
    (converter_control & ~`ADCST_WMASK) == 32'h0) else $error("reserved");
  start_now_a: assert property (
    wr && hit && wdata[26:24] == 3'h1 && !wdata[16] && !conv_busy |=> conv_start) else $error("now");
  no_start_a: assert property (
    st == 3'h0 && $past(st) == 3'h0 && !bst && !$past(bst) |-> !conv_start) else $error("zero");
  single_len_a: assert property (
    conv_start && !bst && !$past(bst) |-> busy11 ##1 (conv_done && !conv_busy)) else $error("length");
  start_idle_a: assert property (
    conv_start && !bst && !$past(bst) |-> !$past(conv_busy) || $past(wr && hit)) else $error("busy");
  bits_a: assert property (
    conv_done && !bst && !$past(bst, 12) |-> conv_bits == 4'hA) else $error("bits");
endmodule
bind adcst_ctrl adcst_props adcst_props_i (.ref_clk, .nrst, .addr, .wdata, .wr, .rd, .rdata,
  .converter_control, .conv_start, .conv_busy, .conv_done, .conv_bits);

// file: dv/testbench.sv
// bench: register access, start modes, burst pacing
// assumes the design and the timer model
`timescale 1ns/1ps
`include "adcst_map.svh"
module testbench
  import adcst_pkg::*;
;
  logic        ref_clk, nrst, wr, rd, conv_start, conv_busy, conv_done, ok;
  logic [31:0] addr, wdata, rdata, converter_control, v;
  logic [5:0]  lv, m;
  logic [3:0]  conv_bits;
  adcst_trig_s trig;
  int          fail_count, comparisons, cyc, n;
  adcst_timers adcst_timers_i (.ref_clk, .lv, .trig);
  adcst_ctrl adcst_ctrl_i (.ref_clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .trig,
    .converter_control, .conv_start, .conv_busy, .conv_done, .conv_bits);
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  task stop_test;
    if (fail_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(string nm, logic [31:0] s, logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task wreg(logic [31:0] a, logic [31:0] d);
    @(posedge ref_clk) {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge ref_clk) wr <= 0;
  endtask
  task rreg(logic [31:0] a);
    @(posedge ref_clk) {rd, addr} <= {1'b1, a};
    @(posedge ref_clk) rd <= 0;
    #1 v = rdata;
  endtask
  // cycles until start or done, 30 means none
  task wt(bit dn);
    n = 0;
    #1;
    while ((dn ? conv_done : conv_start) !== 1'b1 && n < 30) begin
      @(posedge ref_clk) #1;
      n++;
    end
  endtask
  always @(posedge ref_clk) if (++cyc == 3000) begin
    fail_count++;
    stop_test;
  end
  initial begin
    {nrst, wr, rd, addr, wdata, lv} = 0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1;
    // burst with start zero and reserved bits zero, as software must
    wreg(`ADCST_CTRL_ADDR, 32'h002FFFFF);
    rreg(`ADCST_CTRL_ADDR);
    chk("ctrl", v, 32'h002FFFFF);
    rreg(32'h4001C004);
    chk("unmapped", v, 0);
    wt(1);
    @(posedge ref_clk);
    wt(1);
    chk("period", n, 3);
    wreg(`ADCST_CTRL_ADDR, 0);
    repeat (12) @(posedge ref_clk);
    wreg(`ADCST_CTRL_ADDR, 32'h01000000);
    wt(0);
    chk("now", n, 0);
    wt(1);
    chk("single", n, 11);
    for (int s = 0; s < 8; s++)
      for (int e = 0; e < 2; e++)
        if (s != 1) begin
          m = s > 1 ? 6'h20 >> (s - 2) : 6'h0;
          wreg(`ADCST_CTRL_ADDR, 0);
          lv <= {6{e[0]}};
          repeat (4) @(posedge ref_clk);
          wreg(`ADCST_CTRL_ADDR, {4'h0, e[0], s[2:0], 24'h0});
          @(posedge ref_clk) lv <= lv ^ ~m;
          wt(0);
          ok = n == 30;
          @(posedge ref_clk) lv <= lv ^ m;
          wt(0);
          ok &= m ? n > 2 && n < 6 : n == 30;
          wt(1);
          @(posedge ref_clk) lv <= lv ^ m;
          wt(0);
          chk("trig", ok && n == 30, 1);
        end
    stop_test;
  end
endmodule
